// file: spi_chain_cfg.svh
// constants shared by both ends of the status chain link
// assumes a 250 MHz reference clock on both ends
`ifndef SPI_CHAIN_CFG_SVH
`define SPI_CHAIN_CFG_SVH

// ======================================================
// status word layout
`define STATUS_RESET 16'h0000
`define ST_OCS_BIT 15
`define ST_PSF_BIT 14
`define ST_ULD_BIT 13
`define ST_TW_BIT 0
`define ST_CH_LSB 1
`define GROUP_SIZE 6

// ======================================================
// channel status codes
`define CODE_OFF 2'h0
`define CODE_OCS 2'h1
`define CODE_ULD 2'h2
`define CODE_ON 2'h3

// ======================================================
// command word layout
`define CMD_RESET 16'h0000
`define CMD_SRR_BIT 15
`define CMD_GRP_BIT 14
`define GRP_LO_MASK 12'h03F
`define GRP_HI_MASK 12'hFC0

// ======================================================
// frame length counter
`define CNT_RESET 5'h00
`define CNT_VALID 5'h10
`define CNT_LAST 5'h17

// ======================================================
// host registers
`define HOST_REG_TXD 8'h00
`define HOST_REG_CTRL 8'h04
`define HOST_REG_STAT 8'h08
`define HOST_REG_RXD 8'h0C
`define HOST_CTRL_START_BIT 8
`define HOST_LEN_RESET 6'h10
`define HOST_MAX_LEN 6'h20

// ======================================================
// link timing
`define REF_CLK_NS 4
`define SCLK_HALF_NS 64
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `REF_CLK_NS - 1) / `REF_CLK_NS)

`endif

// file: spi_chain_pkg.sv
// types shared by both ends of the status chain link
// assumes spi_chain_cfg.svh for numeric constants
package spi_chain_pkg;

  typedef logic [1:0] chan_code_t;
  typedef logic [15:0] status_word_t;

  typedef enum logic [2:0] {
    H_IDLE,
    H_LEAD,
    H_HIGH,
    H_LOW,
    H_TAIL,
    H_GAP
  } host_state_t;

endpackage : spi_chain_pkg

// file: spi_link_if.sv
// serial link between host master and status chain device
// assumes serial out idles low when the device does not drive it
`timescale 1ns/100ps
interface spi_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic so;
  logic so_oe;
  logic miso;

  // ======================================================
  // resolve the three-state serial out, weak pull low
  assign miso = so_oe ? so : 1'b0;

  modport device (
    input cs_n,
    input sclk,
    input mosi,
    output so,
    output so_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output mosi,
    input miso
  );
endinterface : spi_link_if

// file: spi_chain_host.sv
// host master end: drives frames of 1 to 32 bits over the link
// assumes a register port on ref_clk_in and the device on the link
`timescale 1ns/100ps
`include "spi_chain_cfg.svh"
module spi_chain_host
  import spi_chain_pkg::*;
#(
  parameter int HALF_CYC = `SCLK_HALF_CYC
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  spi_link_if.host link
);

  host_state_t state_q;
  logic [15:0] tmr_q;
  logic [5:0] len_q;
  logic [5:0] left_q;
  logic [31:0] txd_q;
  logic [31:0] tx_q;
  logic [31:0] rx_q;
  logic pre_q;
  logic cs_n_q;
  logic sclk_q;
  logic mosi_q;
  logic miso_m;
  logic miso_s;
  logic tmr_done;
  logic start;

  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.mosi = mosi_q;
  assign tmr_done = (tmr_q == 16'(HALF_CYC - 1));
  assign start = wr_in && (addr_in == `HOST_REG_CTRL) && wdata_in[`HOST_CTRL_START_BIT]
                 && (state_q == H_IDLE) && (wdata_in[5:0] != 6'h00)
                 && (wdata_in[5:0] <= `HOST_MAX_LEN);

  // ======================================================
  // serial in synchroniser
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      miso_m <= 1'b0;
      miso_s <= 1'b0;
    end else if (ce_in) begin
      miso_m <= link.miso;
      miso_s <= miso_m;
    end
  end

  // ======================================================
  // registers
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      txd_q <= 32'h00000000;
    end else if (ce_in && wr_in && addr_in == `HOST_REG_TXD) begin
      txd_q <= wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= 32'h00000000;
    end else if (ce_in) begin
      rdata_out <= 32'h00000000;
      if (rd_in) begin
        unique case (addr_in)
          `HOST_REG_TXD: rdata_out <= txd_q;
          `HOST_REG_CTRL: rdata_out <= {26'h0000000, len_q};
          `HOST_REG_STAT: rdata_out <= {30'h00000000, pre_q, state_q != H_IDLE};
          `HOST_REG_RXD: rdata_out <= rx_q;
          default: rdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // ======================================================
  // frame sequencer
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= H_IDLE;
      tmr_q <= 16'h0000;
      len_q <= `HOST_LEN_RESET;
      left_q <= 6'h00;
      tx_q <= 32'h00000000;
      rx_q <= 32'h00000000;
      pre_q <= 1'b0;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
    end else if (ce_in) begin
      tmr_q <= tmr_done ? 16'h0000 : tmr_q + 16'h0001;
      unique case (state_q)
        H_IDLE: begin
          tmr_q <= 16'h0000;
          if (start) begin
            len_q <= wdata_in[5:0];
            left_q <= wdata_in[5:0];
            tx_q <= txd_q << (6'd32 - wdata_in[5:0]);
            mosi_q <= txd_q[wdata_in[4:0] - 5'd1];
            cs_n_q <= 1'b0;
            rx_q <= 32'h00000000;
            state_q <= H_LEAD;
          end
        end
        H_LEAD: if (tmr_done) begin
          pre_q <= miso_s;
          sclk_q <= 1'b1;
          state_q <= H_HIGH;
        end
        H_HIGH: if (tmr_done) begin
          sclk_q <= 1'b0;
          rx_q <= {rx_q[30:0], miso_s};
          tx_q <= {tx_q[30:0], 1'b0};
          mosi_q <= tx_q[30];
          left_q <= left_q - 6'h01;
          state_q <= (left_q == 6'h01) ? H_TAIL : H_LOW;
        end
        H_LOW: if (tmr_done) begin
          sclk_q <= 1'b1;
          state_q <= H_HIGH;
        end
        H_TAIL: if (tmr_done) begin
          cs_n_q <= 1'b1;
          mosi_q <= 1'b0;
          state_q <= H_GAP;
        end
        H_GAP: if (tmr_done) begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

endmodule : spi_chain_host

// file: spi_chain_device.sv
// device end: status word, frame length check and daisy chain path
// assumes link pins from another domain and fault events on ref_clk_in
//
// Overview of operation
// - power-on reset clears whole status word
// - bits 12:1 hold six channel fields
// - bits 15,14,13,0 report faults as one
// - channel field priority code off/ocs/uld/on
// - underload then overcurrent shows 10 then 01
// - no direct move from overcurrent to underload
// - frame valid only at multiples of eight
// - first sixteen modulo 16, then modulo 8
// - valid frame loads last sixteen input bits
// - serial out pre-bit is shutdown or input
// - pre-bit shown at chip select fall
// - status bits follow first rising clock edge
// - master idles select high, data low
// - chained devices share clock phase and polarity
// - farther byte device word goes first
// - master keeps chain order and length
// - upstream shutdown pre-bit passes through unchanged
// - previous input bit 14 picks channel group
// - status frozen in frame, updated at end; kept unchanged after a valid frame with bit 15 set
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "spi_chain_cfg.svh"
module spi_chain_device
  import spi_chain_pkg::*;
#(
  parameter int NUM_CH = 12
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic [NUM_CH-1:0] oc_event_in,
  input wire logic [NUM_CH-1:0] ul_event_in,
  input wire logic [NUM_CH-1:0] out_active_in,
  input wire logic supply_fault_in,
  input wire logic thermal_warning_in,
  input wire logic thermal_shutdown_in,
  output logic [15:0] cmd_data_out,
  output logic cmd_load_out,
  output logic frame_error_out,
  output logic [15:0] status_word_out,
  spi_link_if.device link
);

  // ======================================================
  // functions
  function automatic chan_code_t chan_code(input logic oc, input logic ul, input logic on);
    chan_code_t code;
    code = `CODE_OFF;
    if (oc) begin
      code = `CODE_OCS;
    end else if (ul) begin
      code = `CODE_ULD;
    end else if (on) begin
      code = `CODE_ON;
    end
    return code;
  endfunction : chan_code

  function automatic status_word_t build_status(
    input logic grp,
    input logic [NUM_CH-1:0] oc,
    input logic [NUM_CH-1:0] ul,
    input logic [NUM_CH-1:0] on,
    input logic supply_fault_flag,
    input logic tw
  );
    status_word_t w;
    int base;
    w = `STATUS_RESET;
    base = grp ? `GROUP_SIZE : 0;
    for (int i = 0; i < `GROUP_SIZE; i++) begin
      w[`ST_CH_LSB + 2*i +: 2] = chan_code(oc[base+i], ul[base+i], on[base+i]);
    end
    w[`ST_OCS_BIT] = |(grp ? oc[NUM_CH-1:`GROUP_SIZE] : oc[`GROUP_SIZE-1:0]);
    w[`ST_PSF_BIT] = supply_fault_flag;
    w[`ST_ULD_BIT] = |(grp ? ul[NUM_CH-1:`GROUP_SIZE] : ul[`GROUP_SIZE-1:0]);
    w[`ST_TW_BIT] = tw;
    return w;
  endfunction : build_status

  function automatic logic [4:0] cnt_next(input logic [4:0] cnt);
    logic [4:0] n;
    n = cnt + 5'h01;
    if (cnt == `CNT_LAST) begin
      n = `CNT_VALID;
    end
    return n;
  endfunction : cnt_next

  // ======================================================
  // declarations
  logic cs_m;
  logic cs_s;
  logic cs_p;
  logic sclk_m;
  logic sclk_s;
  logic sclk_p;
  logic si_m;
  logic si_s;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic first_q;
  logic [4:0] cnt_q;
  logic [15:0] sh_q;
  logic so_q;
  logic so_oe_q;
  logic [15:0] cmd_q;
  logic channel_group_select_q;
  status_word_t status_q;
  logic [NUM_CH-1:0] oc_q;
  logic [NUM_CH-1:0] ul_q;
  logic tsd_q;
  logic frame_ok;
  logic srr_now;
  logic grp_next;
  logic [NUM_CH-1:0] clr_mask;
  logic [NUM_CH-1:0] oc_kept;

  assign link.so = so_q;
  assign link.so_oe = so_oe_q;
  assign cmd_data_out = cmd_q;
  assign status_word_out = status_q;

  // ======================================================
  // pin synchronisers and edge detect
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_p <= 1'b1;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_p <= 1'b0;
      si_m <= 1'b0;
      si_s <= 1'b0;
    end else if (ce_in) begin
      cs_m <= link.cs_n;
      cs_s <= cs_m;
      cs_p <= cs_s;
      sclk_m <= link.sclk;
      sclk_s <= sclk_m;
      sclk_p <= sclk_s;
      si_m <= link.mosi;
      si_s <= si_m;
    end
  end

  assign cs_fall = cs_p && !cs_s;
  assign cs_rise = !cs_p && cs_s;
  assign sclk_rise = !cs_s && !sclk_p && sclk_s;
  assign frame_ok = cs_rise && (cnt_q == `CNT_VALID);
  assign srr_now = frame_ok && sh_q[`CMD_SRR_BIT];
  assign grp_next = frame_ok ? sh_q[`CMD_GRP_BIT] : channel_group_select_q;
  assign clr_mask = !srr_now ? {NUM_CH{1'b0}} :
                    (sh_q[`CMD_GRP_BIT] ? `GRP_HI_MASK : `GRP_LO_MASK);
  assign oc_kept = oc_q & ~clr_mask;

  // ======================================================
  // frame length counter
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_q <= `CNT_RESET;
    end else if (ce_in) begin
      if (cs_fall) begin
        cnt_q <= `CNT_RESET;
      end else if (sclk_rise) begin
        cnt_q <= cnt_next(cnt_q);
      end
    end
  end

  // ======================================================
  // shift register and serial out
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sh_q <= `STATUS_RESET;
      first_q <= 1'b0;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (ce_in) begin
      if (cs_fall) begin
        sh_q <= status_q;
        first_q <= 1'b1;
        so_oe_q <= 1'b1;
        so_q <= tsd_q | si_s;
      end else if (cs_rise) begin
        first_q <= 1'b0;
        so_oe_q <= 1'b0;
        so_q <= 1'b0;
      end else if (sclk_rise) begin
        first_q <= 1'b0;
        so_q <= sh_q[15];
        sh_q <= {sh_q[14:0], si_s};
      end else if (first_q) begin
        so_q <= tsd_q | si_s;
      end
    end
  end

  // ======================================================
  // command data register
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cmd_q <= `CMD_RESET;
      channel_group_select_q <= 1'b0;
      cmd_load_out <= 1'b0;
      frame_error_out <= 1'b0;
    end else if (ce_in) begin
      cmd_load_out <= frame_ok;
      frame_error_out <= cs_rise && !frame_ok;
      if (frame_ok) begin
        cmd_q <= sh_q;
        channel_group_select_q <= sh_q[`CMD_GRP_BIT];
      end
    end
  end

  // ======================================================
  // fault latches, set wins over clear
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      oc_q <= {NUM_CH{1'b0}};
      ul_q <= {NUM_CH{1'b0}};
      tsd_q <= 1'b0;
    end else if (ce_in) begin
      oc_q <= oc_kept | oc_event_in;
      ul_q <= (ul_q & ~clr_mask) | (ul_event_in & ~oc_kept & ~oc_event_in);
      tsd_q <= (tsd_q & ~srr_now) | thermal_shutdown_in;
    end
  end

  // ======================================================
  // status snapshot
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      status_q <= `STATUS_RESET;
    end else if (ce_in) begin
      if (cs_rise && !srr_now) begin
        status_q <= build_status(grp_next, oc_q, ul_q, out_active_in,
                                 supply_fault_in, thermal_warning_in);
      end
    end
  end

endmodule : spi_chain_device

// file: spi_chain_assertions.sv
// checker for the serial link between the host and device ends
// assumes the link signals and the shared clock and reset as inputs
`timescale 1ns/100ps
module spi_chain_assertions (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic so,
  input wire logic so_oe
);
  logic [2:0] age_q;

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  // ======================================================
  // cycles since the last serial clock rise
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      age_q <= 3'h7;
    end else if ($rose(sclk)) begin
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end

  // ======================================================
  // link properties
  a_reset_quiet: assert property ($fell(reset_in) |-> !so_oe && !so)
    else $error("serial out active after reset");
  a_oe_on: assert property ($fell(cs_n) |-> ##[2:4] so_oe)
    else $error("serial out not enabled after select");
  a_oe_off: assert property ($rose(cs_n) |-> ##[2:4] !so_oe)
    else $error("serial out not released after frame");
  a_prebit_or: assert property ($rose(so_oe) |-> so || !$past(mosi, 2))
    else $error("pre-bit lost the serial input");
  a_shift_edge: assert property (so_oe && $past(so_oe) && !cs_n && $changed(so)
    |-> age_q <= 3'h5)
    else $error("serial out moved away from a clock rise");
  a_idle_lines: assert property (cs_n |-> !sclk && !mosi)
    else $error("clock or data not low between frames");
  a_lead_gap: assert property ($fell(cs_n) |-> !sclk [*4])
    else $error("clock rose too soon after select");
  a_sclk_width: assert property ($rose(sclk) |-> sclk [*4])
    else $error("serial clock high too short");

  c_prebit_set: cover property ($rose(so_oe) && so);
  c_frame_end: cover property ($rose(cs_n));
  c_shift: cover property ($rose(sclk) && !cs_n);
endmodule : spi_chain_assertions

// file: half_bridge_spi_status_chain_tb.sv
// self-checking bench: host and device ends joined by one link
// assumes both ends share one 250 MHz clock and one reset
`timescale 1ns/100ps
`include "spi_chain_cfg.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module half_bridge_spi_status_chain_tb import spi_chain_pkg::*; ();
  logic ref_clk_in = 1'b0;
  logic reset_in, wr_in, rd_in, rd_q, tsd_in, psf_in, tw_in, tsd_m, grp;
  logic cmd_load_out, frame_error_out;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out, e32;
  logic [11:0] oc_in, ul_in, act_in, ocm, ulm;
  logic [15:0] cmd_data_out, status_word_out, cmd_m;
  status_word_t snap;
  logic [17:0] e18;
  logic [31:0] rq[$];
  logic [17:0] fq[$];
  int n_tests, err_total;
  integer seed;

  spi_link_if lnk();
  spi_chain_host spi_chain_host_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .ce_in(1'b1),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .link(lnk));
  spi_chain_device spi_chain_device_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .ce_in(1'b1), .oc_event_in(oc_in), .ul_event_in(ul_in), .out_active_in(act_in),
    .supply_fault_in(psf_in), .thermal_warning_in(tw_in), .thermal_shutdown_in(tsd_in),
    .cmd_data_out(cmd_data_out), .cmd_load_out(cmd_load_out),
    .frame_error_out(frame_error_out), .status_word_out(status_word_out), .link(lnk));
  spi_chain_assertions spi_chain_assertions_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .cs_n(lnk.cs_n), .sclk(lnk.sclk), .mosi(lnk.mosi), .so(lnk.so), .so_oe(lnk.so_oe));

  always #2 ref_clk_in = ~ref_clk_in;

  // ======================================================
  // expected status word for one channel group
  function automatic status_word_t exp_st(input logic g);
    status_word_t s;
    int b;
    s = {1'b0, psf_in, 13'h0000, tw_in};
    for (int i = 0; i < 6; i++) begin
      b = g ? i + 6 : i;
      s[15] |= ocm[b];
      s[13] |= ulm[b];
      s[2*i+1 +: 2] = ocm[b] ? `CODE_OCS : ulm[b] ? `CODE_ULD : act_in[b] ? `CODE_ON : `CODE_OFF;
    end
    return s;
  endfunction : exp_st

  // ======================================================
  // register port access, a read notes its expected data
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) rq.push_back(d);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wdata_in <= d;
    @(posedge ref_clk_in);
  endtask : acc

  // one-cycle fault events on the device side
  task ev(input logic [11:0] o, input logic [11:0] u, input logic t);
    oc_in <= o;
    ul_in <= u;
    tsd_in <= t;
    @(posedge ref_clk_in);
    oc_in <= 12'h000;
    ul_in <= 12'h000;
    tsd_in <= 1'b0;
    @(posedge ref_clk_in);
    ocm = ocm | o;
    ulm = ulm | (u & ~ocm);
    tsd_m = tsd_m | t;
  endtask : ev

  // one frame from the host, then the received bits and status
  task frame(input int len, input logic [31:0] d);
    logic v;
    logic [31:0] rx;
    int k;
    v = len >= 16 && len % 8 == 0;
    rx = len > 16 ? (32'(snap) << (len - 16)) | (d >> 16) : 32'(snap) >> (16 - len);
    fq.push_back({!v, v, v ? d[15:0] : cmd_m});
    cmd_m = v ? d[15:0] : cmd_m;
    acc(1'b1, `HOST_REG_TXD, d);
    acc(1'b1, `HOST_REG_CTRL, 32'h100 | 32'(len));
    wr_in <= 1'b0;
    k = 0;
    while (!(cmd_load_out | frame_error_out) && k < 3000) begin
      @(negedge ref_clk_in);
      k++;
    end
    if (k == 3000) begin
      err_total++;
      conclude();
    end
    repeat (32) @(posedge ref_clk_in);
    acc(1'b0, `HOST_REG_RXD, rx);
    acc(1'b0, `HOST_REG_STAT, {30'h0, tsd_m | d[len-1], 1'b0});
    rd_in <= 1'b0;
    grp = v ? d[14] : grp;
    if (v && d[15]) begin
      ocm &= d[14] ? ~`GRP_HI_MASK : ~`GRP_LO_MASK;
      ulm &= d[14] ? ~`GRP_HI_MASK : ~`GRP_LO_MASK;
      tsd_m = 1'b0;
    end else begin
      snap = exp_st(grp);
    end
    @(posedge ref_clk_in);
    `CHK(status_word_out, snap)
  endtask : frame

  task conclude;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // ======================================================
  // result watcher
  always @(posedge ref_clk_in) begin
    rd_q <= rd_in;
    if (rd_q === 1'b1) begin
      e32 = rq.pop_front();
      `CHK(rdata_out, e32)
    end
    if ((cmd_load_out | frame_error_out) === 1'b1) begin
      e18 = fq.pop_front();
      `CHK({frame_error_out, cmd_load_out, cmd_data_out}, e18)
    end
  end

  // ======================================================
  // main sequence
  initial begin
    seed = 32'h2433CA54;
    reset_in = 1'b1;
    {wr_in, rd_in, tsd_in, tsd_m, grp} = 5'h00;
    addr_in = 8'h00;
    wdata_in = 32'h0;
    {oc_in, ul_in, ocm, ulm} = 48'h0;
    cmd_m = 16'h0000;
    snap = 16'h0000;
    psf_in = 1'b1;
    act_in = 12'($random(seed));
    tw_in = 1'($random(seed));
    n_tests = 0;
    err_total = 0;
    repeat (10) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    `CHK(status_word_out, 16'h0000)
    `CHK(cmd_data_out, 16'h0000)
    acc(1'b0, 8'h10, 32'h0);
    acc(1'b0, `HOST_REG_RXD, 32'h0);
    rd_in <= 1'b0;
    @(posedge ref_clk_in);
    ev(12'h100, 12'h004, 1'b0);
    frame(16, 32'h0000);
    ev(12'h004, 12'h100, 1'b0);
    frame(16, 32'h4000);
    frame(24, 32'hA50123);
    frame(12, 32'h0FFF);
    frame(8, 32'h5A);
    ev(12'h000, 12'h000, 1'b1);
    frame(16, 32'h0000);
    frame(16, 32'h8000);
    frame(16, 32'h0000);
    frame(16, 32'h0000);
    conclude();
  end
endmodule : half_bridge_spi_status_chain_tb
